// [swba_pkg.sv]
/*
  swba_pkg: shared constants and types for the snoop write-back
  arbitration pair (cache-side sequencer and system-side arbiter).
  Assumes a single 25 MHz clock shared by both ends.
*/
`default_nettype none

package swba_pkg;

  localparam int unsigned SWBA_ADDR_W = 32;
  localparam int unsigned SWBA_DATA_W = 32;
  // line is four 32-bit words, burst starts at offset zero
  localparam int unsigned SWBA_BURST_LEN = 4;
  localparam logic [1:0] SWBA_BURST_START = 2'h0;
  localparam logic [1:0] SWBA_BURST_LAST = 2'h3;
  // snoop result valid two clocks after the strobe
  localparam int unsigned SWBA_SNOOP_LAT = 2;
  // write-back starts two clocks after a pending access ends
  localparam int unsigned SWBA_WB_AFTER_ACC = 2;
  // line base mask: clears the byte offset within a 16-byte line
  localparam logic [SWBA_ADDR_W-1:0] SWBA_LINE_MASK = 32'hffff_fff0;

  typedef enum logic [0:0] {
    SWBA_INV_SHARE,
    SWBA_INV_DROP
  } swba_inv_t;

endpackage

`default_nettype wire

// [swba_if.sv]
/*
  swba_if: the bus between the cache-side sequencer and the system
  arbiter. Address bus is two-way; the pair of enables resolves it.
  Assumes both modules share sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface swba_if
  import swba_pkg::*;
();
  // arbitration
  logic bus_hold;
  logic bus_hold_acknowledge;
  logic address_hold;
  // snoop
  logic external_snoop_strobe_n;
  logic snoop_invalidate;
  logic hit_modified_n;
  // bus cycle
  logic address_strobe_n;
  logic cacheable_n;
  logic write_read;
  logic last_transfer_n;
  logic burst_ready_n;
  logic ready_n;
  logic [SWBA_DATA_W-1:0] data;
  // two-way address bus
  logic [SWBA_ADDR_W-1:0] addr_cpu_o;
  logic addr_cpu_oe;
  logic [SWBA_ADDR_W-1:0] addr_sys_o;
  logic addr_sys_oe;
  logic [SWBA_ADDR_W-1:0] addr;

  assign addr = addr_cpu_oe ? addr_cpu_o : (addr_sys_oe ? addr_sys_o : '0);

  modport cpu (
    input bus_hold, address_hold, external_snoop_strobe_n, snoop_invalidate,
    input burst_ready_n, ready_n, addr,
    output bus_hold_acknowledge, hit_modified_n, address_strobe_n, cacheable_n,
    output write_read, last_transfer_n, data, addr_cpu_o, addr_cpu_oe
  );

  modport sys (
    output bus_hold, address_hold, external_snoop_strobe_n, snoop_invalidate,
    output burst_ready_n, ready_n, addr_sys_o, addr_sys_oe,
    input bus_hold_acknowledge, hit_modified_n, address_strobe_n, cacheable_n,
    input write_read, last_transfer_n, data, addr
  );
endinterface

`default_nettype wire

// [swba_burst_cnt.sv]
/*
  swba_burst_cnt: word counter for one four-word write-back burst.
  Assumes the owner pulses start once per burst and step per ready.
*/
`timescale 1ns/1ps
`default_nettype none

module swba_burst_cnt
  import swba_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic step,
  // state
  output logic [1:0] word_idx,
  output logic last
);

  logic [1:0] idx_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      idx_reg <= SWBA_BURST_START;
    else if (start)
      idx_reg <= SWBA_BURST_START;
    else if (step && idx_reg != SWBA_BURST_LAST)
      idx_reg <= idx_reg + 2'h1;
  end

  assign word_idx = idx_reg;
  assign last = (idx_reg == SWBA_BURST_LAST);

endmodule

`default_nettype wire

// [swba_cpu.sv]
/*
  swba_cpu: cache-side snoop and modified-line write-back sequencer.
  Assumes the system arbiter keeps its own timing obligations; the
  line store is modelled by a small tag array fed from the user side.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - snoop strobe only after acknowledge held one clock
// - invalidate selects shared or invalid after write-back
// - further snoop strobes ignored until write-back done
// - hit-modified valid two clocks after strobe
// - arbiter drops hold after hit-modified goes low
// - write-back is burst write after hold release
// - burst ends when last and burst-ready low
// - hit-modified high clock after final transfer
// - pending access completes before acknowledging hold
// - arbiter restarts master, new snoop strobe
// - hold kept until clock after hit-modified
// - arbiter re-asserts hold within write-back window
// - non-burst ready write-back ignores hold
// - address hold kept clock past hit-modified
// - address hold floats address next clock
// - snoop strobe two clocks after address hold
// - pending access first, write-back two clocks later
// - arbiter latches snoop address for write-back
// - address driven next clock after hold removed
// - four-word burst starting at offset zero
module swba_cpu
  import swba_pkg::*;
#(
  parameter int unsigned LINES = 16
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bus
  swba_if.cpu bus,
  // user side: mark a line modified, issue a processor access
  input wire logic mark_valid,
  input wire logic [SWBA_ADDR_W-1:0] mark_addr,
  input wire logic acc_req,
  input wire logic [SWBA_ADDR_W-1:0] acc_addr,
  input wire logic acc_write,
  // user side status
  output logic acc_busy,
  output logic wb_busy
);

  localparam int unsigned IDX_W = $clog2(LINES);

  typedef enum logic [2:0] {
    SWBA_C_IDLE,
    SWBA_C_ACC,
    SWBA_C_WAIT,
    SWBA_C_WB_ADS,
    SWBA_C_WB_DATA,
    SWBA_C_WB_END
  } swba_cstate_t;

  swba_cstate_t state_reg;
  logic valid_reg [LINES];
  logic dirty_reg [LINES];
  logic [SWBA_ADDR_W-1:0] tag_reg [LINES];
  logic [1:0] lat_reg;
  logic snoop_busy_reg;
  logic [SWBA_ADDR_W-1:0] snoop_addr_reg;
  logic snoop_inv_reg;
  logic hit_modified_n_pend_reg;
  logic hit_modified_n_n_reg;
  logic bus_hold_acknowledge_reg;
  logic address_hold_d_reg;
  logic acc_pend_reg;
  logic acc_done_reg;
  logic [1:0] gap_reg;
  logic ads_n_reg, cache_n_reg, wr_reg, last_transfer_n_n_reg, aoe_reg;
  logic [SWBA_ADDR_W-1:0] aout_reg;
  logic [SWBA_ADDR_W-1:0] acc_addr_reg;
  logic acc_write_reg;
  logic [1:0] word_idx;
  logic word_last;
  logic xfer_rdy;
  logic wb_start;
  logic [IDX_W-1:0] sidx;
  logic [1:0] next_idx;

  assign sidx = bus.addr[IDX_W+3:4];
  assign xfer_rdy = !bus.burst_ready_n || !bus.ready_n;
  assign wb_start = (state_reg == SWBA_C_WB_ADS);
  // address leads the counter so each beat shows its own word
  assign next_idx = (state_reg == SWBA_C_WB_DATA && xfer_rdy && !word_last) ? word_idx + 2'h1 : word_idx;

  swba_burst_cnt u_cnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(wb_start),
    .step(state_reg == SWBA_C_WB_DATA && xfer_rdy),
    .word_idx(word_idx),
    .last(word_last)
  );

  ////////////////////////////////////////////////////////////////
  // line store
  for (genvar i = 0; i < LINES; i++)
  begin : g_line
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        valid_reg[i] <= 1'b0;
        dirty_reg[i] <= 1'b0;
        tag_reg[i] <= 32'h0;
      end
      else if (mark_valid && mark_addr[IDX_W+3:4] == IDX_W'(i))
      begin
        valid_reg[i] <= 1'b1;
        dirty_reg[i] <= 1'b1;
        tag_reg[i] <= mark_addr & SWBA_LINE_MASK;
      end
      else if (state_reg == SWBA_C_WB_END && snoop_addr_reg[IDX_W+3:4] == IDX_W'(i))
      begin
        dirty_reg[i] <= 1'b0;
        if (snoop_inv_reg)
          valid_reg[i] <= 1'b0;
      end
      else if (!bus.external_snoop_strobe_n && !snoop_busy_reg && bus.snoop_invalidate
               && sidx == IDX_W'(i) && !dirty_reg[i])
        valid_reg[i] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // snoop capture and hit-modified result
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      snoop_busy_reg <= 1'b0;
      lat_reg <= 2'h0;
      snoop_addr_reg <= 32'h0;
      snoop_inv_reg <= 1'b0;
      hit_modified_n_pend_reg <= 1'b0;
    end
    else if (!snoop_busy_reg && lat_reg == 2'h0 && !bus.external_snoop_strobe_n
             && (bus.bus_hold_acknowledge || bus.address_hold))
    begin
      snoop_addr_reg <= bus.addr & SWBA_LINE_MASK;
      snoop_inv_reg <= bus.snoop_invalidate;
      hit_modified_n_pend_reg <= valid_reg[sidx] && dirty_reg[sidx]
                       && tag_reg[sidx] == (bus.addr & SWBA_LINE_MASK);
      lat_reg <= 2'(SWBA_SNOOP_LAT - 1);
    end
    else if (lat_reg != 2'h0)
    begin
      lat_reg <= lat_reg - 2'h1;
      if (lat_reg == 2'h1 && hit_modified_n_pend_reg)
        snoop_busy_reg <= 1'b1;
    end
    else if (state_reg == SWBA_C_WB_END)
      snoop_busy_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hit_modified_n_n_reg <= 1'b1;
    else if (lat_reg == 2'h1 && hit_modified_n_pend_reg)
      hit_modified_n_n_reg <= 1'b0;
    else if (state_reg == SWBA_C_WB_DATA && xfer_rdy && word_last)
      hit_modified_n_n_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // processor access request latch
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      acc_pend_reg <= 1'b0;
      acc_addr_reg <= 32'h0;
      acc_write_reg <= 1'b0;
    end
    else if (acc_req && !acc_pend_reg)
    begin
      acc_pend_reg <= 1'b1;
      acc_addr_reg <= acc_addr;
      acc_write_reg <= acc_write;
    end
    else if (state_reg == SWBA_C_ACC && xfer_rdy)
      acc_pend_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // bus sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= SWBA_C_IDLE;
      ads_n_reg <= 1'b1;
      cache_n_reg <= 1'b1;
      wr_reg <= 1'b0;
      last_transfer_n_n_reg <= 1'b1;
      gap_reg <= 2'h0;
      acc_done_reg <= 1'b0;
    end
    else
    begin
      ads_n_reg <= 1'b1;
      acc_done_reg <= 1'b0;
      case (state_reg)
        SWBA_C_IDLE:
        begin
          if (!hit_modified_n_n_reg && !bus.bus_hold && !bus_hold_acknowledge_reg)
            state_reg <= SWBA_C_WB_ADS;
          // a pending access runs before a new hold is acknowledged
          else if (acc_pend_reg && hit_modified_n_n_reg && !bus_hold_acknowledge_reg && !bus.address_hold)
          begin
            ads_n_reg <= 1'b0;
            wr_reg <= acc_write_reg;
            cache_n_reg <= 1'b1;
            last_transfer_n_n_reg <= 1'b0;
            state_reg <= SWBA_C_ACC;
          end
        end
        SWBA_C_ACC:
          if (xfer_rdy)
          begin
            last_transfer_n_n_reg <= 1'b1;
            acc_done_reg <= 1'b1;
            gap_reg <= 2'(SWBA_WB_AFTER_ACC - 1);
            state_reg <= SWBA_C_WAIT;
          end
        SWBA_C_WAIT:
          if (gap_reg != 2'h0)
            gap_reg <= gap_reg - 2'h1;
          else if (!hit_modified_n_n_reg && !bus.bus_hold)
            state_reg <= SWBA_C_WB_ADS;
          else if (hit_modified_n_n_reg || bus.bus_hold)
            state_reg <= SWBA_C_IDLE;
        SWBA_C_WB_ADS:
        begin
          ads_n_reg <= 1'b0;
          cache_n_reg <= 1'b0;
          wr_reg <= 1'b1;
          last_transfer_n_n_reg <= 1'b1;
          state_reg <= SWBA_C_WB_DATA;
        end
        SWBA_C_WB_DATA:
        begin
          // hold is not looked at here, so ready-terminated bursts run on
          if (xfer_rdy && word_last)
          begin
            last_transfer_n_n_reg <= 1'b1;
            state_reg <= SWBA_C_WB_END;
          end
          else if (xfer_rdy && word_idx == SWBA_BURST_LAST - 2'h1)
            last_transfer_n_n_reg <= 1'b0;
        end
        SWBA_C_WB_END:
          state_reg <= SWBA_C_IDLE;
        default:
          state_reg <= SWBA_C_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // hold acknowledge: only between cycles, at the earliest three clocks after access end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      bus_hold_acknowledge_reg <= 1'b0;
    else if (!bus.bus_hold)
      bus_hold_acknowledge_reg <= 1'b0;
    else if (state_reg == SWBA_C_IDLE && hit_modified_n_n_reg && !acc_done_reg && !acc_pend_reg)
      bus_hold_acknowledge_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // address bus drive
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      address_hold_d_reg <= 1'b0;
      aoe_reg <= 1'b0;
      aout_reg <= 32'h0;
    end
    else
    begin
      address_hold_d_reg <= bus.address_hold;
      aoe_reg <= !bus.address_hold && !bus_hold_acknowledge_reg;
      if (state_reg == SWBA_C_WB_ADS || state_reg == SWBA_C_WB_DATA)
        aout_reg <= snoop_addr_reg | {28'h0, next_idx, 2'h0};
      else
        aout_reg <= acc_addr_reg;
    end
  end

  assign bus.bus_hold_acknowledge = bus_hold_acknowledge_reg;
  assign bus.hit_modified_n = hit_modified_n_n_reg;
  assign bus.address_strobe_n = ads_n_reg;
  assign bus.cacheable_n = cache_n_reg;
  assign bus.write_read = wr_reg;
  assign bus.last_transfer_n = last_transfer_n_n_reg;
  assign bus.data = {30'h0, word_idx};
  assign bus.addr_cpu_o = aout_reg;
  assign bus.addr_cpu_oe = aoe_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      acc_busy <= 1'b0;
      wb_busy <= 1'b0;
    end
    else
    begin
      acc_busy <= acc_pend_reg;
      wb_busy <= !hit_modified_n_n_reg;
    end
  end

endmodule

`default_nettype wire

// [swba_sys.sv]
/*
  swba_sys: system-side arbiter for snoops by an external master.
  Assumes one external master whose requests arrive on the user side.
*/
`timescale 1ns/1ps
`default_nettype none

module swba_sys
  import swba_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bus
  swba_if.sys bus,
  // user side
  input wire logic ext_req,
  input wire logic ext_write,
  input wire logic [SWBA_ADDR_W-1:0] ext_addr,
  input wire logic use_address_hold,
  input wire logic use_rdy,
  // status
  output logic ext_backoff,
  output logic snoop_done
);

  typedef enum logic [2:0] {
    SWBA_S_IDLE,
    SWBA_S_HOLD,
    SWBA_S_SNOOP,
    SWBA_S_RESULT,
    SWBA_S_WB,
    SWBA_S_DONE
  } swba_sstate_t;

  swba_sstate_t state_reg;
  logic hold_reg, address_hold_reg, external_snoop_strobe_n_reg, inv_reg, backoff_reg, done_reg;
  logic burst_ready_n_n_reg, rdy_n_reg, aoe_reg;
  logic [SWBA_ADDR_W-1:0] latch_addr_reg;
  logic [1:0] wait_reg;
  logic hit_modified_n_seen_reg;
  logic [1:0] beat_reg;

  // word offset of the current write-back beat for the latched address
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || state_reg != SWBA_S_WB)
      beat_reg <= 2'h0;
    else if (!burst_ready_n_n_reg || !rdy_n_reg)
      beat_reg <= beat_reg + 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= SWBA_S_IDLE;
      hold_reg <= 1'b0;
      address_hold_reg <= 1'b0;
      external_snoop_strobe_n_reg <= 1'b1;
      inv_reg <= 1'b0;
      backoff_reg <= 1'b0;
      done_reg <= 1'b0;
      wait_reg <= 2'h0;
      hit_modified_n_seen_reg <= 1'b0;
      latch_addr_reg <= 32'h0;
      aoe_reg <= 1'b0;
    end
    else
    begin
      external_snoop_strobe_n_reg <= 1'b1;
      done_reg <= 1'b0;
      case (state_reg)
        SWBA_S_IDLE:
          if (ext_req)
          begin
            hold_reg <= !use_address_hold;
            address_hold_reg <= use_address_hold;
            wait_reg <= 2'h0;
            state_reg <= SWBA_S_HOLD;
          end
        SWBA_S_HOLD:
          // wait one clock past acknowledge, or two after address hold
          if (use_address_hold ? wait_reg == 2'(SWBA_SNOOP_LAT - 1) : bus.bus_hold_acknowledge)
          begin
            if (use_address_hold || wait_reg != 2'h0)
            begin
              external_snoop_strobe_n_reg <= 1'b0;
              inv_reg <= ext_write;
              aoe_reg <= 1'b1;
              latch_addr_reg <= ext_addr & SWBA_LINE_MASK;
              wait_reg <= 2'h0;
              state_reg <= SWBA_S_SNOOP;
            end
            else
              wait_reg <= wait_reg + 2'h1;
          end
          else if (use_address_hold)
            wait_reg <= wait_reg + 2'h1;
        SWBA_S_SNOOP:
        begin
          if (wait_reg == 2'(SWBA_SNOOP_LAT - 1))
            state_reg <= SWBA_S_RESULT;
          else
            wait_reg <= wait_reg + 2'h1;
        end
        SWBA_S_RESULT:
          if (!bus.hit_modified_n && !hit_modified_n_seen_reg)
            hit_modified_n_seen_reg <= 1'b1;
          else if (hit_modified_n_seen_reg)
          begin
            hold_reg <= 1'b0;
            backoff_reg <= 1'b1;
            aoe_reg <= address_hold_reg;
            state_reg <= SWBA_S_WB;
          end
          else
          begin
            hold_reg <= 1'b0;
            address_hold_reg <= 1'b0;
            aoe_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= SWBA_S_IDLE;
          end
        SWBA_S_WB:
        begin
          if (!bus.address_strobe_n && !use_address_hold)
            hold_reg <= 1'b1;
          if (!bus.hit_modified_n == 1'b0)
          begin
            hit_modified_n_seen_reg <= 1'b0;
            address_hold_reg <= 1'b0;
            aoe_reg <= 1'b0;
            state_reg <= SWBA_S_DONE;
          end
        end
        SWBA_S_DONE:
          if (use_address_hold || bus.bus_hold_acknowledge)
          begin
            backoff_reg <= 1'b0;
            hold_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= SWBA_S_IDLE;
          end
        default:
          state_reg <= SWBA_S_IDLE;
      endcase
    end
  end

  // ready per beat while the device runs a cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      burst_ready_n_n_reg <= 1'b1;
      rdy_n_reg <= 1'b1;
    end
    else
    begin
      burst_ready_n_n_reg <= !(!bus.address_strobe_n || (!burst_ready_n_n_reg && bus.last_transfer_n)) || use_rdy;
      rdy_n_reg <= !(!bus.address_strobe_n || (!rdy_n_reg && bus.last_transfer_n)) || !use_rdy;
    end
  end

  assign bus.bus_hold = hold_reg;
  assign bus.address_hold = address_hold_reg;
  assign bus.external_snoop_strobe_n = external_snoop_strobe_n_reg;
  assign bus.snoop_invalidate = inv_reg;
  assign bus.burst_ready_n = burst_ready_n_n_reg;
  assign bus.ready_n = rdy_n_reg;
  assign bus.addr_sys_o = latch_addr_reg | {28'h0, beat_reg, 2'h0};
  assign bus.addr_sys_oe = aoe_reg;
  assign ext_backoff = backoff_reg;
  assign snoop_done = done_reg;

endmodule

`default_nettype wire

// [swba_checker.sv]
/*
  swba_checker: timing checks on the snoop write-back bus.
  Assumes the interface signals are wired in by name, one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module swba_checker
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // arbitration and snoop
  input wire logic bus_hold,
  input wire logic bus_hold_acknowledge,
  input wire logic address_hold,
  input wire logic external_snoop_strobe_n,
  input wire logic hit_modified_n,
  // bus cycle
  input wire logic address_strobe_n,
  input wire logic cacheable_n,
  input wire logic write_read,
  input wire logic last_transfer_n,
  input wire logic burst_ready_n,
  input wire logic ready_n,
  input wire logic addr_cpu_oe
);
  logic xfer;
  logic wb_on_reg;
  logic [2:0] word_reg;

  assign xfer = !burst_ready_n || !ready_n;

  // open from the write-back strobe until hit-modified returns
  always_ff @(posedge sys_clk)
    if (!rst_n || hit_modified_n)
      wb_on_reg <= 1'b0;
    else if (!address_strobe_n)
      wb_on_reg <= 1'b1;

  always_ff @(posedge sys_clk)
    if (!rst_n || (!address_strobe_n && !hit_modified_n))
      word_reg <= 3'h0;
    else if (xfer && wb_on_reg)
      word_reg <= word_reg + 3'h1;

////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence final_xfer_s;
    !last_transfer_n && xfer && !hit_modified_n;
  endsequence

  ack_before_snoop_a:
    assert property (!external_snoop_strobe_n && !address_hold |-> bus_hold_acknowledge && $past(bus_hold_acknowledge))
    else $error("snoop strobe without settled acknowledge");
  hit_modified_n_latency_a:
    assert property ($fell(hit_modified_n) |-> $past(external_snoop_strobe_n, 2) == 1'b0)
    else $error("hit-modified not two clocks after strobe");
  hold_release_a:
    assert property ($fell(hit_modified_n) && bus_hold |=> bus_hold ##1 !bus_hold)
    else $error("hold not released one clock after hit-modified");
  address_hold_kept_a:
    assert property ($fell(hit_modified_n) && address_hold |=> address_hold)
    else $error("address hold dropped with hit-modified");
  addr_float_a:
    assert property (address_hold && $past(address_hold) |-> !addr_cpu_oe)
    else $error("address driven under address hold");
  wb_start_a:
    assert property (!address_strobe_n && !hit_modified_n |-> write_read && !cacheable_n
      && (address_hold || !$past(bus_hold)))
    else $error("write-back start malformed");
  burst_words_a:
    assert property (final_xfer_s |-> word_reg == 3'h3)
    else $error("write-back burst not four words");
  hit_modified_n_release_a:
    assert property (final_xfer_s |=> hit_modified_n)
    else $error("hit-modified not released after burst");
  hit_modified_n_hold_a:
    assert property ($rose(hit_modified_n) |-> $past(last_transfer_n) == 1'b0 && $past(xfer))
    else $error("hit-modified released early");
  ack_after_done_a:
    assert property ($rose(bus_hold_acknowledge) |-> $past(hit_modified_n) && !$past(xfer))
    else $error("acknowledge raised too early");
  no_ack_wb_a:
    assert property (wb_on_reg |-> !bus_hold_acknowledge)
    else $error("acknowledge during write-back");
  address_hold_snoop_a:
    assert property ($rose(address_hold) |-> ##2 !external_snoop_strobe_n)
    else $error("strobe not two clocks after address hold");
endmodule

`default_nettype wire

// [tb_snoop_writeback_arbitration.sv]
/*
  tb_snoop_writeback_arbitration: both ends joined, user sides driven.
  Assumes each snoop finishes well inside the watchdog span.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_snoop_writeback_arbitration
  import swba_pkg::*;
();
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic mark_valid = 1'b0, acc_req = 1'b0, acc_write = 1'b0, ext_req = 1'b0;
  logic ext_write = 1'b0, use_address_hold = 1'b0, use_rdy = 1'b0;
  logic [31:0] mark_addr = '0, acc_addr = '0, ext_addr = '0;
  logic acc_busy, snoop_done, wb_busy, ext_backoff;
  int mismatches = 0, n_checks = 0, cyc = 0, k = 0;

  swba_if bus_if ();
  swba_cpu #(.LINES(16)) u_swba_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if.cpu), .mark_valid(mark_valid),
    .mark_addr(mark_addr), .acc_req(acc_req), .acc_addr(acc_addr), .acc_write(acc_write), .acc_busy(acc_busy),
    .wb_busy(wb_busy));
  swba_sys u_swba_sys (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if.sys), .ext_req(ext_req), .ext_write(ext_write),
    .ext_addr(ext_addr), .use_address_hold(use_address_hold), .use_rdy(use_rdy), .ext_backoff(ext_backoff),
    .snoop_done(snoop_done));
  swba_checker u_swba_checker (.sys_clk(sys_clk), .rst_n(rst_n), .bus_hold(bus_if.bus_hold),
    .bus_hold_acknowledge(bus_if.bus_hold_acknowledge), .address_hold(bus_if.address_hold),
    .external_snoop_strobe_n(bus_if.external_snoop_strobe_n), .hit_modified_n(bus_if.hit_modified_n),
    .address_strobe_n(bus_if.address_strobe_n), .cacheable_n(bus_if.cacheable_n), .write_read(bus_if.write_read),
    .last_transfer_n(bus_if.last_transfer_n), .burst_ready_n(bus_if.burst_ready_n), .ready_n(bus_if.ready_n),
    .addr_cpu_oe(bus_if.addr_cpu_oe));

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic test_done();
    k++;
    $display("test %0d done", k);
  endtask

  task automatic mark(input logic [31:0] a);
    @(negedge sys_clk);
    mark_valid = 1'b1;
    mark_addr = a;
    @(negedge sys_clk);
    mark_valid = 1'b0;
  endtask

  // access stays pending while the bus is held; bounded waits only
  task automatic access(input logic [31:0] a, input logic wr);
    int n;
    n = 0;
    @(negedge sys_clk);
    acc_addr = a;
    acc_write = wr;
    acc_req = 1'b1;
    while (acc_busy !== 1'b1 && n < 400)
    begin
      @(negedge sys_clk);
      n++;
    end
    acc_req = 1'b0;
    while (acc_busy === 1'b1 && n < 800)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("access done", acc_busy, 1'b0);
  endtask

  // sampled at falling edges, where the flops have settled
  task automatic run_snoop(input logic [31:0] a, input logic wr, input logic ah, input logic rd, input logic hit);
    int t_s, t_h, t_r, t_w, w, n;
    logic xf;
    t_s = -1;
    t_h = -1;
    t_r = -1;
    t_w = -1;
    w = 0;
    n = 0;
    @(negedge sys_clk);
    ext_addr = a;
    ext_write = wr;
    use_address_hold = ah;
    use_rdy = rd;
    ext_req = 1'b1;
    while (!(snoop_done === 1'b1 && bus_if.hit_modified_n === 1'b1 && t_s >= 0) && n < 400)
    begin
      @(negedge sys_clk);
      n++;
      xf = (bus_if.burst_ready_n & bus_if.ready_n) === 1'b0;
      if (w == 4 && t_w >= 0)
      begin
        check("hit_modified_n release", bus_if.hit_modified_n, 1'b1);
        t_w = -2;
      end
      if (t_s < 0 && bus_if.external_snoop_strobe_n === 1'b0)
        t_s = cyc;
      if (t_h < 0 && bus_if.hit_modified_n === 1'b0)
        t_h = cyc;
      if (t_w == -1 && t_h >= 0 && bus_if.address_strobe_n === 1'b0)
      begin
        t_w = cyc;
        check("wb cacheable", bus_if.cacheable_n, 1'b0);
        check("backoff", ext_backoff, 1'b1);
        check("wb busy", wb_busy, 1'b1);
        if (t_r >= t_h)
          check("wb after access", t_w - t_r, 2);
      end
      else if (t_w == -1 && xf)
        t_r = cyc;
      if (t_w >= 0 && bus_if.hit_modified_n === 1'b0 && xf)
      begin
        check("wb addr", bus_if.addr, (a & SWBA_LINE_MASK) | 32'(w * 4));
        check("wb write", bus_if.write_read, 1'b1);
        check("wb last", bus_if.last_transfer_n, w != 3);
        w++;
      end
    end
    check("snoop ends", n < 400, 1'b1);
    check("words", w, hit ? 4 : 0);
    if (hit)
      check("hit_modified_n delay", t_h - t_s, 2);
    else
      check("no hit_modified_n", t_h, -1);
    ext_req = 1'b0;
    repeat (4) @(negedge sys_clk);
    test_done();
  endtask

////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    mark(32'h0000_0100);
    run_snoop(32'h0000_0108, 1'b1, 1'b0, 1'b0, 1'b1);
    run_snoop(32'h0000_0104, 1'b0, 1'b0, 1'b0, 1'b0);
    mark(32'h0000_0210);
    run_snoop(32'h0000_021c, 1'b0, 1'b0, 1'b1, 1'b1);
    run_snoop(32'h0000_0210, 1'b1, 1'b0, 1'b0, 1'b0);
    mark(32'h0000_0320);
    fork
      access(32'h0000_0400, 1'b0);
      run_snoop(32'h0000_032c, 1'b1, 1'b1, 1'b0, 1'b1);
    join
    mark(32'h0000_0430);
    fork
      run_snoop(32'h0000_0434, 1'b0, 1'b0, 1'b0, 1'b1);
      begin
        repeat (6) @(negedge sys_clk);
        access(32'h0000_0500, 1'b1);
      end
    join
    run_snoop(32'h0000_05f0, 1'b0, 1'b1, 1'b0, 1'b0);
    give_verdict();
  end

  // about 150 cycles expected; far longer means a hang
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
endmodule

`default_nettype wire
